/* design/cpf_pkg.sv */
// Purpose: Shared constants for the channel power and output format configuration block
// Assumes: APB word registers, byte address = 4 x register index
// Notes:   Register indices are kept as printed; offsets derive from them
package cpf_pkg;
   // Register indices and byte addresses
   localparam logic [7:0]  CPF_IDX_PWR_DOWN   = 8'h02;
   localparam logic [7:0]  CPF_IDX_FEATURE    = 8'h03;
   localparam logic [7:0]  CPF_IDX_SCAN_CTRL  = 8'h10;
   localparam logic [7:0]  CPF_IDX_STATUS     = 8'h11;
   localparam logic [11:0] CPF_ADDR_PWR_DOWN  = {2'h0, CPF_IDX_PWR_DOWN, 2'h0};
   localparam logic [11:0] CPF_ADDR_FEATURE   = {2'h0, CPF_IDX_FEATURE, 2'h0};
   localparam logic [11:0] CPF_ADDR_SCAN_CTRL = {2'h0, CPF_IDX_SCAN_CTRL, 2'h0};
   localparam logic [11:0] CPF_ADDR_STATUS    = {2'h0, CPF_IDX_STATUS, 2'h0};
   // Reset values
   localparam logic [7:0]  CPF_RST_PWR_DOWN   = 8'h00;
   localparam logic [7:0]  CPF_RST_FEATURE    = 8'h00;
   localparam logic [7:0]  CPF_RST_SCAN_EN    = 8'hFF;
   // Feature select fields
   localparam int          CPF_FS_DEV_LSB     = 6;
   localparam int          CPF_FS_ALERT_BIT   = 4;
   localparam logic [7:0]  CPF_FS_WR_MASK     = 8'hD7;
   // Scan control fields
   localparam int          CPF_SC_AUTO_BIT    = 0;
   localparam int          CPF_SC_MAN_LSB     = 4;
   localparam int          CPF_SC_EN_LSB      = 8;
   // Output frame formats
   localparam logic [2:0]  CPF_FMT_PLAIN      = 3'h0;
   localparam logic [2:0]  CPF_FMT_CHAN       = 3'h1;
   localparam logic [2:0]  CPF_FMT_CHAN_DEV   = 3'h2;
   localparam logic [2:0]  CPF_FMT_FULL       = 3'h3;
   // Frame timing in serial clock falling edges
   localparam logic [5:0]  CPF_FIRST_OUT_FALL = 6'd16;
   localparam int          CPF_FRAME_BITS     = 25;
   localparam logic [5:0]  CPF_FALL_MAX       = 6'd63;
endpackage : cpf_pkg

/* design/cpf_sync2.sv */
// Purpose: Two flip-flop synchroniser for pin inputs
// Assumes: Inputs are asynchronous levels
// Notes:   First stage feeds only the second stage
`timescale 1ns/10ps
module cpf_sync2 #(
   parameter int W     = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // Clock and reset
   input  wire logic         pclk,
   input  wire logic         presetn,
   // Data
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   logic [W-1:0] meta_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_q   <= RST_VAL;
         sync_out <= RST_VAL;
      end else begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule : cpf_sync2

/* design/cpf_fifo.sv */
// Purpose: Small valid/ready buffer between converter results and the frame shifter
// Assumes: Single clock, DEPTH a power of two
// Notes:   Full drops in_ready, so a stalled frame side back-pressures the source
`timescale 1ns/10ps
module cpf_fifo #(
   parameter int W     = 16,
   parameter int DEPTH = 2
) (
   // Clock and reset
   input  wire logic         pclk,
   input  wire logic         presetn,
   // Fill side
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   // Drain side
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic      [W-1:0] out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   logic [W-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0]   cnt_q;
   wire push = in_valid & in_ready;
   wire pop  = out_valid & out_ready;

   assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data  = mem_q[rd_q];

   always_ff @(posedge pclk) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push) wr_q <= wr_q + 1'b1;
         if (pop)  rd_q <= rd_q + 1'b1;
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : cpf_fifo

/* design/cpf_cfg_top.sv */
// Purpose: Channel power-down and output frame format configuration, APB slave
// Assumes: sclk and cs_n arrive from the serial host, sampled by pclk
// Notes:   sclk must be well below pclk/4 for clean edge detection
//
// What this block does
// - Bit n set powers down channel n
// - Power-down register resets to all zeros
// - All channels off gives invalid output
// - Manual channel off: invalid, may false-alert
// - Powered-down channel leaves the auto scan
// - Bits 7-6 hold chain position, reset 00
// - Bit 4 enables threshold alert, reset 0
// - Bits 5 and 3 read zero
// - Result bits 24-9 from 16th falling edge
// - Format selects channel, device, range tail bits
// - Channel tag is binary channel number
// - Device tag is id; range tag three LSBs
// - Auto scan steps ascending, new channel each
`timescale 1ns/10ps
module cpf_cfg_top
   import cpf_pkg::*;
#(
   parameter int NCH   = 8,
   parameter int DEPTH = 2
) (
   // Clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   // APB slave
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [11:0]      paddr,
   input  wire logic [31:0]      pwdata,
   output logic      [31:0]      prdata,
   output logic                  pready,
   output logic                  pslverr,
   // Serial link
   input  wire logic             sclk,
   input  wire logic             cs_n,
   output logic                  sdo,
   output logic                  sdo_oe,
   // Converter side
   input  wire logic             conv_valid,
   output logic                  conv_ready,
   input  wire logic [15:0]      conv_data,
   input  wire logic [4*NCH-1:0] range_codes,
   output logic                  conv_start,
   output logic      [2:0]       conv_chan,
   output logic      [NCH-1:0]   front_end_off,
   output logic                  alert_enable,
   output logic                  data_invalid
);
   import cpf_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // Registers
   logic [7:0]     pwr_down_q;
   logic [7:0]     feature_q;
   logic [15:0]    scan_ctrl_q;
   logic [7:0]     pd_shadow_q;
   logic [7:0]     fs_shadow_q;
   logic [2:0]     chan_q;
   logic           invalid_q;
   logic           frame_q;
   logic [5:0]     fall_cnt_q;
   logic [CPF_FRAME_BITS-1:0] shift_q;
   logic           sdo_q;
   logic           sclk_s;
   logic           cs_n_s;
   logic           sclk_d1_q;
   logic           cs_d1_q;

   wire apb_wr   = psel & penable & pwrite;
   wire hit_pd   = (paddr == CPF_ADDR_PWR_DOWN);
   wire hit_fs   = (paddr == CPF_ADDR_FEATURE);
   wire hit_sc   = (paddr == CPF_ADDR_SCAN_CTRL);
   wire hit_st   = (paddr == CPF_ADDR_STATUS);
   wire hit_any  = hit_pd | hit_fs | hit_sc | hit_st;
   wire wr_pd    = apb_wr & hit_pd;
   wire wr_fs    = apb_wr & hit_fs;
   wire wr_sc    = apb_wr & hit_sc & !hit_st;

   // Zero wait states; unmapped addresses answer with an error
   assign pready  = 1'b1;
   assign pslverr = psel & penable & !hit_any;

   wire [31:0] rd_pd = {24'h0, pwr_down_q};
   wire [31:0] rd_fs = {24'h0, feature_q};
   wire [31:0] rd_sc = {16'h0, scan_ctrl_q};
   wire [31:0] rd_st = {22'h0, invalid_q, frame_q, 5'h0, chan_q};
   assign prdata = hit_pd ? rd_pd :
                   hit_fs ? rd_fs :
                   hit_sc ? rd_sc :
                   hit_st ? rd_st : 32'h0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pwr_down_q  <= CPF_RST_PWR_DOWN;
         feature_q   <= CPF_RST_FEATURE;
         scan_ctrl_q <= {CPF_RST_SCAN_EN, 8'h00};
      end else begin
         if (wr_pd) pwr_down_q  <= pwdata[7:0];
         if (wr_fs) feature_q   <= pwdata[7:0] & CPF_FS_WR_MASK;
         if (wr_sc) scan_ctrl_q <= pwdata[15:0];
      end
   end

   wire       auto_mode = scan_ctrl_q[CPF_SC_AUTO_BIT];
   wire [2:0] man_chan  = scan_ctrl_q[CPF_SC_MAN_LSB +: 3];
   wire [7:0] scan_en   = scan_ctrl_q[CPF_SC_EN_LSB +: 8];

   assign front_end_off = pwr_down_q[NCH-1:0];
   assign alert_enable  = feature_q[CPF_FS_ALERT_BIT];

   ////////////////////////////////////////////////////////////////////////////////
   // Link sampling
   cpf_sync2 #(.W(2), .RST_VAL(2'b01)) u_sync (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in ({sclk, cs_n}),
      .sync_out ({sclk_s, cs_n_s})
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sclk_d1_q <= 1'b0;
         cs_d1_q   <= 1'b1;
      end else begin
         sclk_d1_q <= sclk_s;
         cs_d1_q   <= cs_n_s;
      end
   end

   wire frame_start = cs_d1_q & !cs_n_s;
   wire frame_end   = !cs_d1_q & cs_n_s;
   wire sclk_fall   = sclk_d1_q & !sclk_s & !cs_n_s;

   ////////////////////////////////////////////////////////////////////////////////
   // Scan sequencer
   logic [7:0] eligible;
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_elig
         // Off channels drop out even while enabled for scanning
         assign eligible[gi] = scan_en[gi] & !pwr_down_q[gi];
      end
   endgenerate

   function automatic logic [2:0] cpf_next_chan(input logic [2:0] cur,
                                                input logic [7:0] mask);
      logic [2:0] cand;
      logic       found;
      cpf_next_chan = 3'h0;
      found         = 1'b0;
      for (int i = 1; i <= 8; i++) begin
         cand = cur + 3'(i);
         if (!found && mask[cand]) begin
            cpf_next_chan = cand;
            found         = 1'b1;
         end
      end
   endfunction : cpf_next_chan

   // Ascending wrap search; an empty set falls back to channel 0
   wire [2:0] auto_next = cpf_next_chan(chan_q, eligible);
   wire [2:0] sel_chan  = auto_mode ? auto_next : man_chan;
   // All off, or a manual pick that is off, yields invalid data
   wire       sel_off   = (pwr_down_q == 8'hFF) | pwr_down_q[sel_chan];

   ////////////////////////////////////////////////////////////////////////////////
   // Frame control
   logic       fifo_valid;
   logic [15:0] fifo_data;
   wire load     = frame_q & sclk_fall & (fall_cnt_q == CPF_FIRST_OUT_FALL - 6'd1);
   wire shift_en = frame_q & sclk_fall & (fall_cnt_q >= CPF_FIRST_OUT_FALL);

   cpf_fifo #(.W(16), .DEPTH(DEPTH)) u_fifo (
      .pclk      (pclk),
      .presetn   (presetn),
      .in_valid  (conv_valid),
      .in_ready  (conv_ready),
      .in_data   (conv_data),
      .out_valid (fifo_valid),
      .out_ready (load),
      .out_data  (fifo_data)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pd_shadow_q <= CPF_RST_PWR_DOWN;
         fs_shadow_q <= CPF_RST_FEATURE;
         chan_q      <= 3'h7;
         invalid_q   <= 1'b0;
         conv_start  <= 1'b0;
      end else begin
         conv_start <= frame_start;
         if (frame_start) begin
            // Format and device id are frozen per frame; front_end_off and alert_enable follow writes at once
            pd_shadow_q <= pwr_down_q;
            fs_shadow_q <= feature_q;
            chan_q      <= sel_chan;
            invalid_q   <= sel_off;
         end
      end
   end

   assign conv_chan    = chan_q;
   assign data_invalid = invalid_q;

   wire [2:0] fmt     = fs_shadow_q[2:0];
   wire [1:0] dev_id  = fs_shadow_q[CPF_FS_DEV_LSB +: 2];
   wire [3:0] ch_tag  = {1'b0, chan_q};
   wire [2:0] rng_tag = range_codes[4*chan_q +: 3];
   wire [15:0] result = fifo_valid ? fifo_data : 16'h0000;
   // Unused tail bits stay low in every format
   wire [8:0] tail = (fmt == CPF_FMT_CHAN)     ? {ch_tag, 5'h00} :
                     (fmt == CPF_FMT_CHAN_DEV) ? {ch_tag, dev_id, 3'h0} :
                     (fmt == CPF_FMT_FULL)     ? {ch_tag, dev_id, rng_tag} :
                                                 9'h000;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         frame_q    <= 1'b0;
         fall_cnt_q <= 6'd0;
         shift_q    <= '0;
         sdo_q      <= 1'b0;
      end else begin
         if (frame_start) begin
            frame_q    <= 1'b1;
            fall_cnt_q <= 6'd0;
         end else if (frame_end) begin
            frame_q    <= 1'b0;
         end else if (sclk_fall && fall_cnt_q != CPF_FALL_MAX) begin
            fall_cnt_q <= fall_cnt_q + 6'd1;
         end
         if (load) begin
            shift_q <= {result[14:0], tail, 1'b0};
            sdo_q   <= result[15];
         end else if (shift_en) begin
            shift_q <= {shift_q[CPF_FRAME_BITS-2:0], 1'b0};
            sdo_q   <= shift_q[CPF_FRAME_BITS-1];
         end else if (!frame_q) begin
            sdo_q   <= 1'b0;
         end
      end
   end

   assign sdo    = sdo_q;
   assign sdo_oe = frame_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   sequence s_load;
      frame_q && sclk_fall && fall_cnt_q == 6'd15;
   endsequence

   property p_pd_write;
      @(posedge pclk) disable iff (!presetn)
      wr_pd |=> front_end_off == $past(pwdata[7:0]);
   endproperty
   a_pd_write: assert property (p_pd_write) else $error("power-down write lost");

   property p_pd_reset;
      @(posedge pclk) disable iff (!presetn)
      $rose(presetn) |-> pwr_down_q == 8'h00;
   endproperty
   a_pd_reset: assert property (p_pd_reset) else $error("power-down not zero");

   property p_all_off;
      @(posedge pclk) disable iff (!presetn)
      frame_start && pwr_down_q == 8'hFF |=> data_invalid ##1 data_invalid;
   endproperty
   a_all_off: assert property (p_all_off) else $error("all-off not invalid");

   property p_scan_skip;
      @(posedge pclk) disable iff (!presetn)
      frame_start && auto_mode && eligible != 8'h00 |=> !pd_shadow_q[conv_chan];
   endproperty
   a_scan_skip: assert property (p_scan_skip) else $error("off channel scanned");

   property p_dev_id;
      @(posedge pclk) disable iff (!presetn)
      wr_fs |=> feature_q[7:6] == $past(pwdata[7:6]) && alert_enable == $past(pwdata[4]);
   endproperty
   a_dev_id: assert property (p_dev_id) else $error("feature fields wrong");

   property p_rsv_zero;
      @(posedge pclk) disable iff (!presetn)
      wr_fs |=> rd_fs[5] == 1'b0 && rd_fs[3] == 1'b0 [*2];
   endproperty
   a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bit set");

   property p_msb_first;
      @(posedge pclk) disable iff (!presetn)
      s_load |=> sdo == $past(result[15]) && shift_q[24:10] == $past(result[14:0]);
   endproperty
   a_msb_first: assert property (p_msb_first) else $error("result not msb first");

   property p_plain_tail;
      @(posedge pclk) disable iff (!presetn)
      s_load and (fmt == CPF_FMT_PLAIN) |=> shift_q[9:1] == 9'h000;
   endproperty
   a_plain_tail: assert property (p_plain_tail) else $error("tail not low");

   property p_frozen;
      @(posedge pclk) disable iff (!presetn)
      frame_q && !frame_start |=> $stable(fs_shadow_q) && $stable(pd_shadow_q);
   endproperty
   a_frozen: assert property (p_frozen) else $error("config changed mid-frame");
endmodule : cpf_cfg_top

/* dv/cpf_host_model.sv */
// Purpose: Serial host model, runs one read frame per start pulse
// Assumes: sdo settles a few pclk after each sclk fall
// Notes:   sclk stands high between frames; 40 falls per frame
`timescale 1ns/10ps
module cpf_host_model #(
   parameter realtime HALF = 62.5
) (
   // Request
   input  wire logic        start,
   output logic      [7:0]  frame_cnt,
   output logic      [24:0] frame,
   // Serial link
   output logic             sclk,
   output logic             cs_n,
   input  wire logic        sdo
);
   initial begin
      sclk = 1'b1;
      cs_n = 1'b1;
      frame_cnt = 8'h00;
      frame = 25'h0;
      forever begin
         @(posedge start);
         #(HALF) cs_n = 1'b0;
         for (int n = 1; n <= 40; n++) begin
            #(HALF) sclk = 1'b0;
            // Sample half a period later, well after the pclk-delayed update
            #(HALF) sclk = 1'b1;
            if (n >= 16) begin
               frame = {frame[23:0], sdo};
            end
         end
         #(HALF) cs_n = 1'b1;
         frame_cnt = frame_cnt + 8'h01;
      end
   end
endmodule : cpf_host_model

/* dv/tb.sv */
// Purpose: Self-checking bench for the power and output format block
// Assumes: Zero-wait APB slave, host model on the serial side
// Notes:   Converter words are pushed by the bench before most frames; some frames run with the buffer empty
`timescale 1ns/10ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin fails++; \
   $display("CHECK FAILED %s exp %0h seen %0h", n, e, g); end end
module tb;
   import cpf_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, range_codes;
   logic        sclk, cs_n, sdo, sdo_oe, start, conv_valid, conv_ready;
   logic [15:0] conv_data;
   logic        conv_start, alert_enable, data_invalid;
   logic [2:0]  conv_chan;
   logic [7:0]  front_end_off, frame_cnt;
   logic [24:0] frame;
   int          fails, total_checks;
////////////////////////////////////////////////////////////////////////////////
   cpf_cfg_top cpf_cfg_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .sclk(sclk), .cs_n(cs_n),
      .sdo(sdo), .sdo_oe(sdo_oe), .conv_valid(conv_valid), .conv_ready(conv_ready),
      .conv_data(conv_data), .range_codes(range_codes), .conv_start(conv_start),
      .conv_chan(conv_chan), .front_end_off(front_end_off),
      .alert_enable(alert_enable), .data_invalid(data_invalid));
   cpf_host_model cpf_host_model_i (.start(start), .frame_cnt(frame_cnt),
      .frame(frame), .sclk(sclk), .cs_n(cs_n), .sdo(sdo));
   always #4 pclk = ~pclk;
////////////////////////////////////////////////////////////////////////////////
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic err);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Only the watchdog ends a wait for the slave
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask : wr
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] x, input logic xe);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0, r, e);
      `CHK("prdata", x, r)
      `CHK("pslverr", xe, e)
   endtask : rd_chk
   task automatic push(input logic [15:0] w);
      @(posedge pclk);
      conv_valid <= 1'b1;
      conv_data <= w;
      do begin
         @(posedge pclk);
      end while (conv_ready !== 1'b1);
      conv_valid <= 1'b0;
   endtask : push
   task automatic run_frame;
      logic [7:0] c0;
      c0 = frame_cnt;
      @(posedge pclk);
      start <= 1'b1;
      @(posedge pclk);
      start <= 1'b0;
      while (frame_cnt === c0) begin
         @(posedge pclk);
      end
   endtask : run_frame
   task automatic frame_chk(input logic [15:0] res, input logic [2:0] ch,
                            input logic [2:0] f, input logic [1:0] dv);
      logic [8:0] t;
      t = 9'h000;
      if (f == 3'h1) t = {1'b0, ch, 5'h00};
      if (f == 3'h2) t = {1'b0, ch, dv, 3'h0};
      if (f == 3'h3) t = {1'b0, ch, dv, range_codes[4*ch +: 3]};
      run_frame();
      `CHK("frame", {res, t}, frame)
      `CHK("conv_chan", ch, conv_chan)
   endtask : frame_chk
   task automatic print_verdict;
      $display("checks %0d fails %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : print_verdict
////////////////////////////////////////////////////////////////////////////////
   initial begin
      #400000;
      fails++;
      print_verdict();
   end
   initial begin
      logic [2:0] seq [7];
      {pclk, presetn, psel, penable, pwrite, start, conv_valid} = 7'h00;
      // Auto scan starts after channel 0, the last manual pick, skipping 2 and 5
      seq = '{3'h1, 3'h3, 3'h4, 3'h6, 3'h7, 3'h0, 3'h1};
      paddr = 12'h000;
      pwdata = 32'h0;
      conv_data = 16'h0000;
      range_codes = 32'hFEDCBA98;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      rd_chk(CPF_ADDR_PWR_DOWN, 32'h0, 1'b0);
      rd_chk(CPF_ADDR_FEATURE, 32'h0, 1'b0);
      `CHK("alert_enable", 1'b0, alert_enable)
      wr(CPF_ADDR_FEATURE, 32'h000000D7);
      rd_chk(CPF_ADDR_FEATURE, 32'h000000D7, 1'b0);
      `CHK("alert_enable", 1'b1, alert_enable)
      wr(CPF_ADDR_PWR_DOWN, 32'h000000A5);
      rd_chk(CPF_ADDR_PWR_DOWN, 32'h000000A5, 1'b0);
      `CHK("front_end_off", 8'hA5, front_end_off)
      rd_chk(12'h100, 32'h0, 1'b1);
      wr(CPF_ADDR_PWR_DOWN, 32'h0);
      wr(CPF_ADDR_SCAN_CTRL, 32'h0000FF50);
      // Two words fill the buffer while no frame drains it
      push(16'hA55A);
      push(16'h1234);
      repeat (3) @(posedge pclk);
      `CHK("conv_ready", 1'b0, conv_ready)
      frame_chk(16'hA55A, 3'h5, 3'h7, 2'h3);
      frame_chk(16'h1234, 3'h5, 3'h7, 2'h3);
      frame_chk(16'h0000, 3'h5, 3'h7, 2'h3);
      for (int f = 0; f < 8; f++) begin
         wr(CPF_ADDR_FEATURE, {24'h0, f[1:0], 3'h0, f[2:0]});
         push(16'h8001 + 16'(f));
         frame_chk(16'h8001 + 16'(f), 3'h5, f[2:0], f[1:0]);
      end
      `CHK("data_invalid", 1'b0, data_invalid)
      wr(CPF_ADDR_FEATURE, 32'h01);
      push(16'h0F0F);
      fork
         frame_chk(16'h0F0F, 3'h5, 3'h1, 2'h0);
         begin
            repeat (150) @(posedge pclk);
            wr(CPF_ADDR_FEATURE, 32'h43);
         end
      join
      push(16'hF0F0);
      frame_chk(16'hF0F0, 3'h5, 3'h3, 2'h1);
      wr(CPF_ADDR_PWR_DOWN, 32'h20);
      run_frame();
      `CHK("data_invalid", 1'b1, data_invalid)
      wr(CPF_ADDR_SCAN_CTRL, 32'h0000FF00);
      wr(CPF_ADDR_PWR_DOWN, 32'hFF);
      run_frame();
      `CHK("data_invalid", 1'b1, data_invalid)
      wr(CPF_ADDR_PWR_DOWN, 32'h24);
      wr(CPF_ADDR_FEATURE, 32'h01);
      wr(CPF_ADDR_SCAN_CTRL, 32'h0000FF01);
      foreach (seq[i]) begin
         push({13'h0, seq[i]});
         frame_chk({13'h0, seq[i]}, seq[i], 3'h1, 2'h0);
      end
      `CHK("data_invalid", 1'b0, data_invalid)
      // Frame end reaches sdo_oe only after the cs_n synchroniser
      repeat (6) @(posedge pclk);
      `CHK("sdo_oe", 1'b0, sdo_oe)
      `CHK("sdo", 1'b0, sdo)
      print_verdict();
   end
endmodule : tb
